// ===== fad_defines.vh
`ifndef FAD_DEFINES_VH
`define FAD_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define FAD_ADR_TERM_SEL 8'h00
`define FAD_ADR_MAX_FREQ 8'h04
`define FAD_ADR_STD_SET 8'h08
`define FAD_ADR_ACC_ON1 8'h0c
`define FAD_ADR_DEC_OFF1 8'h10
`define FAD_ADR_ACC_ON2 8'h14
`define FAD_ADR_DEC_OFF2 8'h18
`define FAD_ADR_STATUS 8'h1c
`define FAD_ADR_BANDS 8'h20

// ****************************************
// terminal function codes
// ****************************************
`define FAD_CODE_CONST_SPEED 5'h01
`define FAD_CODE_OVER_FREQ1 5'h02
`define FAD_CODE_SET_FREQ1 5'h06
`define FAD_CODE_OVER_FREQ2 5'h18
`define FAD_CODE_SET_FREQ2 5'h19

// ****************************************
// field positions
// ****************************************
`define FAD_SEL0_LSB 0
`define FAD_SEL1_LSB 8
`define FAD_SEL2_LSB 16
`define FAD_ST_VALID_BIT 8
`define FAD_ST_BUSY_BIT 9
`define FAD_ST_RUN_BIT 10
`define FAD_ST_ACC_BIT 11
`define FAD_ST_DEC_BIT 12

// ****************************************
// reset values and band divisors
// ****************************************
`define FAD_RST_TERM_SEL 32'h00060201
`define FAD_RST_MAX_FREQ 16'h1770
`define FAD_RST_FREQ 16'h0000
`define FAD_ON_DIVISOR 16'h0064
`define FAD_OFF_DIVISOR 16'h0032

`endif

// ===== fad_div.v
`timescale 1ns/100ps
// ****************************************
// restoring divider by a constant, one quotient bit per clock
// ****************************************
module fad_div #(
    parameter W = 16,
    parameter [15:0] DIVISOR = 16'h0064
) (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // request
    input wire start_in,
    input wire [W-1:0] dividend_in,
    // result
    output reg busy_out,
    output reg done_out,
    output reg [W-1:0] quotient_out
);
    localparam integer CNT_W = W;
    localparam [5:0] CNT_INIT = CNT_W[5:0];
    reg [W-1:0] dvd_reg;
    reg [W-1:0] quo_reg;
    reg [W:0] rem_reg;
    reg [5:0] cnt_reg;
    wire [W:0] trial = {rem_reg[W-1:0], dvd_reg[W-1]};
    wire [W:0] div_w = {{(W+1-16){1'b0}}, DIVISOR};
    wire fits = trial >= div_w;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dvd_reg <= {W{1'b0}};
            quo_reg <= {W{1'b0}};
            rem_reg <= {(W+1){1'b0}};
            cnt_reg <= 6'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            quotient_out <= {W{1'b0}};
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                // a restart aborts any division in flight
                dvd_reg <= dividend_in;
                rem_reg <= {(W+1){1'b0}};
                cnt_reg <= CNT_INIT;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                rem_reg <= fits ? trial - div_w : trial;
                dvd_reg <= {dvd_reg[W-2:0], 1'b0};
                quo_reg <= {quo_reg[W-2:0], fits};
                cnt_reg <= cnt_reg - 6'h01;
                if (cnt_reg == 6'h01) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    quotient_out <= {quo_reg[W-2:0], fits};
                end
            end
        end
    end
endmodule // fad_div

// ===== fad_flag.v
`timescale 1ns/100ps
// ****************************************
// one arrival flag with hold between its set and clear points
// ****************************************
module fad_flag (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // conditions
    input wire force_off_in,
    input wire set_in,
    input wire clr_in,
    // state
    output reg flag_out
);
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_out <= 1'b0;
        end else if (force_off_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clr_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule // fad_flag

// ===== fad_top.v
`timescale 1ns/100ps
`include "fad_defines.vh"
// ****************************************
// frequency arrival detector
// ****************************************
module fad_top #(
    parameter FW = 16
) (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    // drive state from the controller, same clock
    input wire [FW-1:0] out_freq_in,
    input wire run_in,
    input wire accel_in,
    input wire decel_in,
    // arrival flags, active high
    output wire [4:0] flags_out,
    // assignable terminals, active low
    output reg [2:0] term_n_out
);

    // ****************************************
    // helper functions
    // ****************************************
    function [31:0] apply_sel;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer b;
        begin
            apply_sel = old_val;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    apply_sel[b*8 +: 8] = new_val[b*8 +: 8];
                end
            end
        end
    endfunction

    // writes land in the low FW bits; upper lanes of the bus word are dropped
    function [FW-1:0] merge_fw;
        input [FW-1:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        reg [31:0] w;
        begin
            w = apply_sel({{(32-FW){1'b0}}, old_val}, new_val, sel);
            merge_fw = w[FW-1:0];
        end
    endfunction

    // clamps at full scale so a threshold near the top cannot wrap to zero
    function [FW-1:0] sat_add;
        input [FW-1:0] a;
        input [FW-1:0] b;
        reg [FW:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            sat_add = s[FW] ? {FW{1'b1}} : s[FW-1:0];
        end
    endfunction

    function [FW-1:0] sat_sub;
        input [FW-1:0] a;
        input [FW-1:0] b;
        begin
            sat_sub = (a > b) ? a - b : {FW{1'b0}};
        end
    endfunction

    function [FW-1:0] abs_diff;
        input [FW-1:0] a;
        input [FW-1:0] b;
        begin
            abs_diff = (a > b) ? a - b : b - a;
        end
    endfunction

    // maps a terminal function code onto the flag it shows
    function pick_flag;
        input [4:0] code;
        input [4:0] flags;
        begin
            case (code)
                `FAD_CODE_CONST_SPEED: begin
                    pick_flag = flags[0];
                end
                `FAD_CODE_OVER_FREQ1: begin
                    pick_flag = flags[1];
                end
                `FAD_CODE_SET_FREQ1: begin
                    pick_flag = flags[2];
                end
                `FAD_CODE_OVER_FREQ2: begin
                    pick_flag = flags[3];
                end
                `FAD_CODE_SET_FREQ2: begin
                    pick_flag = flags[4];
                end
                default: begin
                    pick_flag = 1'b0;
                end
            endcase
        end
    endfunction

    // ****************************************
    // register file
    // ****************************************
    reg [31:0] term_sel_reg;
    reg [FW-1:0] max_freq_reg;
    reg [FW-1:0] std_set_reg;
    reg [FW-1:0] acc_on1_reg;
    reg [FW-1:0] dec_off1_reg;
    reg [FW-1:0] acc_on2_reg;
    reg [FW-1:0] dec_off2_reg;
    reg [FW-1:0] fon_reg;
    reg [FW-1:0] foff_reg;
    reg bands_valid_reg;
    reg band_start_reg;
    reg init_pending_reg;

    wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire bus_wr = bus_req & wb_we_in;
    wire wr_max = bus_wr & (wb_adr_in == `FAD_ADR_MAX_FREQ);

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            term_sel_reg <= `FAD_RST_TERM_SEL;
            max_freq_reg <= `FAD_RST_MAX_FREQ;
            std_set_reg <= `FAD_RST_FREQ;
            acc_on1_reg <= `FAD_RST_FREQ;
            dec_off1_reg <= `FAD_RST_FREQ;
            acc_on2_reg <= `FAD_RST_FREQ;
            dec_off2_reg <= `FAD_RST_FREQ;
        end else if (bus_wr) begin
            case (wb_adr_in)
                `FAD_ADR_TERM_SEL: begin
                    term_sel_reg <= apply_sel(term_sel_reg, wb_dat_in, wb_sel_in) &
                        32'h001f1f1f;
                end
                `FAD_ADR_MAX_FREQ: max_freq_reg <= merge_fw(max_freq_reg, wb_dat_in, wb_sel_in);
                `FAD_ADR_STD_SET: std_set_reg <= merge_fw(std_set_reg, wb_dat_in, wb_sel_in);
                `FAD_ADR_ACC_ON1: acc_on1_reg <= merge_fw(acc_on1_reg, wb_dat_in, wb_sel_in);
                `FAD_ADR_DEC_OFF1: dec_off1_reg <= merge_fw(dec_off1_reg, wb_dat_in, wb_sel_in);
                `FAD_ADR_ACC_ON2: acc_on2_reg <= merge_fw(acc_on2_reg, wb_dat_in, wb_sel_in);
                `FAD_ADR_DEC_OFF2: dec_off2_reg <= merge_fw(dec_off2_reg, wb_dat_in, wb_sel_in);
                default: term_sel_reg <= term_sel_reg;
            endcase
        end
    end

    // ****************************************
    // band derivation
    // ****************************************
    wire on_busy;
    wire on_done;
    wire [FW-1:0] on_quo;
    wire off_done;
    wire [FW-1:0] off_quo;

    fad_div #(
        .W(FW),
        .DIVISOR(`FAD_ON_DIVISOR)
    ) u_on_div (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .start_in(band_start_reg),
        .dividend_in(max_freq_reg),
        .busy_out(on_busy),
        .done_out(on_done),
        .quotient_out(on_quo)
    );

    fad_div #(
        .W(FW),
        .DIVISOR(`FAD_OFF_DIVISOR)
    ) u_off_div (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .start_in(band_start_reg),
        .dividend_in(max_freq_reg),
        .busy_out(),
        .done_out(off_done),
        .quotient_out(off_quo)
    );

    // old bands stay in use until the new pair is complete, so the flags
    // never compare against a half-updated band
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_pending_reg <= 1'b1;
            band_start_reg <= 1'b0;
            bands_valid_reg <= 1'b0;
            fon_reg <= {FW{1'b0}};
            foff_reg <= {FW{1'b0}};
        end else begin
            init_pending_reg <= 1'b0;
            band_start_reg <= init_pending_reg | wr_max;
            if (band_start_reg) begin
                bands_valid_reg <= 1'b0;
            end else if (on_done & off_done) begin
                fon_reg <= on_quo;
                foff_reg <= off_quo;
                bands_valid_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // arrival conditions
    // ****************************************
    wire const_speed = run_in & ~accel_in & ~decel_in;
    wire [FW-1:0] std_dist = abs_diff(out_freq_in, std_set_reg);
    wire [FW-1:0] fup = sat_add(out_freq_in, fon_reg);

    // over-frequency: turn on early by fon while not braking, off late by foff
    wire over1_set = ~decel_in & (fup >= acc_on1_reg);
    wire over1_clr = decel_in & (out_freq_in < sat_sub(dec_off1_reg, foff_reg));
    wire over2_set = ~decel_in & (fup >= acc_on2_reg);
    wire over2_clr = decel_in & (out_freq_in < sat_sub(dec_off2_reg, foff_reg));

    // set-frequency windows, one per ramp direction
    wire win_acc1 = (out_freq_in >= sat_sub(acc_on1_reg, fon_reg)) &
        (out_freq_in <= sat_add(acc_on1_reg, foff_reg));
    wire win_dec1 = (out_freq_in <= sat_add(dec_off1_reg, fon_reg)) &
        (out_freq_in >= sat_sub(dec_off1_reg, foff_reg));
    wire win_acc2 = (out_freq_in >= sat_sub(acc_on2_reg, fon_reg)) &
        (out_freq_in <= sat_add(acc_on2_reg, foff_reg));
    wire win_dec2 = (out_freq_in <= sat_add(dec_off2_reg, fon_reg)) &
        (out_freq_in >= sat_sub(dec_off2_reg, foff_reg));
    wire set1_set = (accel_in & win_acc1) | (decel_in & win_dec1);
    wire set1_clr = (accel_in & ~win_acc1) | (decel_in & ~win_dec1);
    wire set2_set = (accel_in & win_acc2) | (decel_in & win_dec2);
    wire set2_clr = (accel_in & ~win_acc2) | (decel_in & ~win_dec2);

    // ****************************************
    // flag state
    // ****************************************
    fad_flag u_const (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .force_off_in(~const_speed),
        .set_in(std_dist <= fon_reg),
        .clr_in(std_dist > foff_reg),
        .flag_out(flags_out[0])
    );

    fad_flag u_over1 (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .force_off_in(~run_in),
        .set_in(over1_set),
        .clr_in(over1_clr),
        .flag_out(flags_out[1])
    );

    fad_flag u_setf1 (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .force_off_in(~run_in),
        .set_in(set1_set),
        .clr_in(set1_clr),
        .flag_out(flags_out[2])
    );

    fad_flag u_over2 (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .force_off_in(~run_in),
        .set_in(over2_set),
        .clr_in(over2_clr),
        .flag_out(flags_out[3])
    );

    fad_flag u_setf2 (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .force_off_in(~run_in),
        .set_in(set2_set),
        .clr_in(set2_clr),
        .flag_out(flags_out[4])
    );

    // ****************************************
    // terminal drive
    // ****************************************
    reg [2:0] term_n_next;

    always @* begin
        term_n_next[0] = ~pick_flag(term_sel_reg[`FAD_SEL0_LSB +: 5], flags_out);
        term_n_next[1] = ~pick_flag(term_sel_reg[`FAD_SEL1_LSB +: 5], flags_out);
        term_n_next[2] = ~pick_flag(term_sel_reg[`FAD_SEL2_LSB +: 5], flags_out);
    end

    // one register stage costs a cycle but keeps the pins glitch free
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            term_n_out <= 3'h7;
        end else begin
            term_n_out <= term_n_next;
        end
    end

    // ****************************************
    // bus read and acknowledge
    // ****************************************
    reg [31:0] rd_next;
    reg [31:0] status_word;

    always @* begin
        status_word = 32'h00000000;
        status_word[4:0] = flags_out;
        status_word[`FAD_ST_VALID_BIT] = bands_valid_reg;
        status_word[`FAD_ST_BUSY_BIT] = on_busy;
        status_word[`FAD_ST_RUN_BIT] = run_in;
        status_word[`FAD_ST_ACC_BIT] = accel_in;
        status_word[`FAD_ST_DEC_BIT] = decel_in;
        case (wb_adr_in)
            `FAD_ADR_TERM_SEL: rd_next = term_sel_reg;
            `FAD_ADR_MAX_FREQ: rd_next = {{(32-FW){1'b0}}, max_freq_reg};
            `FAD_ADR_STD_SET: rd_next = {{(32-FW){1'b0}}, std_set_reg};
            `FAD_ADR_ACC_ON1: rd_next = {{(32-FW){1'b0}}, acc_on1_reg};
            `FAD_ADR_DEC_OFF1: rd_next = {{(32-FW){1'b0}}, dec_off1_reg};
            `FAD_ADR_ACC_ON2: rd_next = {{(32-FW){1'b0}}, acc_on2_reg};
            `FAD_ADR_DEC_OFF2: rd_next = {{(32-FW){1'b0}}, dec_off2_reg};
            `FAD_ADR_STATUS: rd_next = status_word;
            `FAD_ADR_BANDS: rd_next = {foff_reg[15:0], fon_reg[15:0]};
            default: rd_next = 32'h00000000;
        endcase
    end

    // unmapped addresses are acknowledged, read zero and ignore writes
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= bus_req;
            if (bus_req & ~wb_we_in) begin
                wb_dat_out <= rd_next;
            end
        end
    end

endmodule // fad_top

// ===== fad_chk.sv
`timescale 1ns/100ps
// ****************************************
// arrival detector port checker
// ****************************************
module fad_chk #(
    parameter FW = 16
) (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // bus
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    // drive state
    input wire run_in,
    input wire accel_in,
    input wire decel_in,
    // outputs
    input wire [4:0] flags_out,
    input wire [2:0] term_n_out
);
    reg [31:0] sel_reg;
    wire sel_wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_adr_in == 8'h00;
    // shadow of the terminal codes; assumes whole-word writes to that register
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in)
            sel_reg <= 32'h00060201;
        else if (sel_wr)
            sel_reg <= wb_dat_in & 32'h001f1f1f;
    end
    function pick(input [4:0] code, input [4:0] fl);
        begin
            case (code)
                5'h01: pick = fl[0];
                5'h02: pick = fl[1];
                5'h06: pick = fl[2];
                5'h18: pick = fl[3];
                5'h19: pick = fl[4];
                default: pick = 1'b0;
            endcase
        end
    endfunction
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    property p_ack_next;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_once;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_dat_hold;
        $changed(wb_dat_out) |-> wb_ack_out;
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_const_off;
        !(run_in && !accel_in && !decel_in) |=> !flags_out[0];
    endproperty
    a_const_off: assert property (p_const_off) else $error("const flag on in ramp");
    property p_stop_off;
        !run_in |=> flags_out[4:1] == 4'h0;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("flag on while stopped");
    property p_set_hold;
        run_in && !accel_in && !decel_in |=> $stable(flags_out[2]) && $stable(flags_out[4]);
    endproperty
    a_set_hold: assert property (p_set_hold) else $error("set flag moved");
    property p_over_fall;
        $fell(flags_out[1]) |-> $past(decel_in) || !$past(run_in);
    endproperty
    a_over_fall: assert property (p_over_fall) else $error("over flag fell");
    property p_over_rise;
        $rose(flags_out[3]) |-> $past(run_in) && !$past(decel_in);
    endproperty
    a_over_rise: assert property (p_over_rise) else $error("over flag rose");
    property p_term;
        term_n_out == ~{pick($past(sel_reg[20:16]), $past(flags_out)),
            pick($past(sel_reg[12:8]), $past(flags_out)),
            pick($past(sel_reg[4:0]), $past(flags_out))};
    endproperty
    a_term: assert property (p_term) else $error("terminal level");
endmodule // fad_chk

bind fad_top fad_chk #(.FW(FW)) u_chk (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .run_in(run_in),
    .accel_in(accel_in), .decel_in(decel_in), .flags_out(flags_out),
    .term_n_out(term_n_out)
);

// ===== fad_relay.sv
`timescale 1ns/100ps
// ****************************************
// relay coils on the open-collector terminals
// ****************************************
module fad_relay (
    // clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // terminals, low sinks coil current
    input wire [2:0] term_n_in,
    // coil state
    output reg [2:0] coil_out
);
    // pull-in after one clock; a real coil is far slower
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in)
            coil_out <= 3'h0;
        else
            coil_out <= ~term_n_in;
    end
endmodule // fad_relay

// ===== frequency_arrival_detector_bench.sv
`timescale 1ns/100ps
`include "fad_defines.vh"
// ****************************************
// arrival detector bench
// ****************************************
module frequency_arrival_detector_bench;
    reg mclk_in = 1'b0;
    reg rstn_in = 1'b0;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, acc = 1'b0, dec = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'hf;
    reg [31:0] wdat = 32'h0, seed = 32'h580bfa19;
    reg [15:0] freq = 16'h0;
    reg [23:0] tbl [0:15];
    reg [31:0] exp_q[$], msk_q[$];
    wire [31:0] rdat;
    wire ack;
    wire [4:0] fl;
    wire [2:0] term_n, coil;
    integer fail_count = 0, cmp_count = 0, i, pass;

    always #25 mclk_in = ~mclk_in;

    fad_top #(.FW(16)) u_dut (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .out_freq_in(freq), .run_in(run),
        .accel_in(acc), .decel_in(dec), .flags_out(fl), .term_n_out(term_n)
    );
    fad_relay u_relay (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .term_n_in(term_n), .coil_out(coil)
    );

    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    task test_done;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    function [31:0] rnd(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            rnd = x ^ (x << 5);
        end
    endfunction

    // ****************************************
    // bus and drive tasks
    // ****************************************
    task xfer(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge mclk_in);
            {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
            for (n = 0; n < 20 && ack !== 1'b1; n = n + 1)
                @(posedge mclk_in);
            {cyc, stb, we} <= 3'b000;
            if (n == 20) begin
                fail_count = fail_count + 1;
                test_done;
            end
        end
    endtask

    task rd(input [7:0] a, input [31:0] e, input [31:0] m);
        begin
            exp_q.push_back(e & m);
            msk_q.push_back(m);
            xfer(1'b0, a, 32'h0);
        end
    endtask

    // inputs to coil takes three edges: flag, terminal, relay
    task drive(input [15:0] f, input [2:0] m);
        begin
            @(posedge mclk_in);
            freq <= f;
            {run, acc, dec} <= m;
            repeat (4) @(posedge mclk_in);
        end
    endtask

    always @(posedge mclk_in) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            chk(rdat & msk_q.pop_front(), exp_q.pop_front());
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        // flags, mode {run,acc,dec}, frequency; bands 100 on, 200 off
        tbl[0] = {5'h00, 3'b000, 16'h0000};
        tbl[1] = {5'h00, 3'b110, 16'h0b53};
        tbl[2] = {5'h06, 3'b110, 16'h0b54};
        tbl[3] = {5'h06, 3'b110, 16'h0c80};
        tbl[4] = {5'h02, 3'b110, 16'h0c81};
        tbl[5] = {5'h1a, 3'b110, 16'h0f3c};
        tbl[6] = {5'h1a, 3'b100, 16'h1323};
        tbl[7] = {5'h1b, 3'b100, 16'h1324};
        tbl[8] = {5'h1b, 3'b100, 16'h1450};
        tbl[9] = {5'h1a, 3'b100, 16'h1451};
        tbl[10] = {5'h0a, 3'b101, 16'h1069};
        tbl[11] = {5'h1a, 3'b101, 16'h1004};
        tbl[12] = {5'h02, 3'b101, 16'h0ed7};
        tbl[13] = {5'h06, 3'b101, 16'h0834};
        tbl[14] = {5'h06, 3'b101, 16'h0708};
        tbl[15] = {5'h00, 3'b101, 16'h0707};
        repeat (5) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        rd(`FAD_ADR_TERM_SEL, 32'h00060201, 32'hffffffff);
        rd(`FAD_ADR_MAX_FREQ, 32'h00001770, 32'hffffffff);
        rd(`FAD_ADR_STD_SET, 32'h0, 32'hffffffff);
        rd(`FAD_ADR_BANDS, 32'h0078003c, 32'hffffffff);
        rd(8'h40, 32'h0, 32'hffffffff);
        $display("reset values done");
        xfer(1'b1, `FAD_ADR_MAX_FREQ, 32'h00002710);
        repeat (20) @(posedge mclk_in);
        rd(`FAD_ADR_STATUS, 32'h100, 32'h100);
        rd(`FAD_ADR_BANDS, 32'h00c80064, 32'hffffffff);
        xfer(1'b1, `FAD_ADR_STD_SET, 32'h00001388);
        xfer(1'b1, `FAD_ADR_ACC_ON1, 32'h00000bb8);
        xfer(1'b1, `FAD_ADR_DEC_OFF1, 32'h000007d0);
        xfer(1'b1, `FAD_ADR_ACC_ON2, 32'h00000fa0);
        xfer(1'b1, `FAD_ADR_DEC_OFF2, 32'h00000fa0);
        $display("band change done");
        for (pass = 0; pass < 2; pass = pass + 1) begin
            if (pass == 1)
                xfer(1'b1, `FAD_ADR_TERM_SEL, 32'h00191800);
            for (i = 0; i < 16; i = i + 1) begin
                drive(tbl[i][15:0], tbl[i][18:16]);
                chk({29'h0, coil}, pass ? {29'h0, tbl[i][23:22], 1'b0} :
                    {29'h0, tbl[i][21:19]});
                chk({27'h0, fl}, {27'h0, tbl[i][23:19]});
                rd(`FAD_ADR_STATUS, {27'h0, tbl[i][23:19]}, 32'h1f);
            end
            $display("ramp table pass %0d done", pass);
        end
        // mid-run reset: pins release at once, bands are derived again
        rstn_in <= 1'b0;
        repeat (5) @(posedge mclk_in);
        chk({24'h0, fl, term_n}, 32'h00000007);
        rstn_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        rd(`FAD_ADR_TERM_SEL, 32'h00060201, 32'hffffffff);
        rd(`FAD_ADR_BANDS, 32'h0078003c, 32'hffffffff);
        $display("mid-run reset done");
        for (i = 0; i < 24; i = i + 1) begin
            seed = rnd(seed);
            drive(seed[15:0], {seed[17], seed[16], ~seed[16]});
            rd(`FAD_ADR_STATUS, 32'h0, seed[17] ? 32'h1 : 32'h1f);
        end
        $display("random ramps done");
        test_done;
    end
endmodule // frequency_arrival_detector_bench
